// ---- rtl/atc_pkg.sv ----
// Purpose: Shared constants and types for the converter trigger control
// Assumes: 8-bit register port, one system clock
// Notes:   Offsets are byte addresses on the register port
package atc_pkg;

  // Register offsets
  localparam logic [7:0] CTRL_A_ADDR = 8'h7a;
  localparam logic [7:0] CTRL_B_ADDR = 8'h7b;
  localparam logic [7:0] DIS_ADDR    = 8'h7e;

  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] DIS_RST    = 8'h00;

  // Field positions in converter_control_a
  localparam int A_EN_BIT    = 7;
  localparam int A_START_BIT = 6;
  localparam int A_AUTO_BIT  = 5;
  localparam int A_DONE_BIT  = 4;

  // Field positions in converter_control_b
  localparam int B_MUX_BIT = 6;
  localparam int B_SRC_LSB = 0;
  localparam int SRC_W     = 3;

  // Conversion lengths in converter clocks, one per system clock here
  localparam logic [4:0] CONV_CLOCKS       = 5'h0d;
  localparam logic [4:0] FIRST_CONV_CLOCKS = 5'h19;

  // Trigger sources in field order
  typedef enum logic [SRC_W-1:0] {
    SRC_FREE, SRC_COMP, SRC_EXT0, SRC_T0_CMPA,
    SRC_T0_OVF, SRC_T1_CMPB, SRC_T1_OVF, SRC_T1_CAP
  } atc_src_e;

  // Sequencer states
  typedef enum logic {ST_IDLE, ST_CONV} atc_state_e;

endpackage

// ---- rtl/atc_trig_if.sv ----
// Purpose: Carries trigger flags, selection and the trigger pulse
// Assumes: All signals in the system clock domain
// Notes:   Flag 0 is the conversion-done pulse used for free running
`timescale 1ns/1ps
interface atc_trig_if;
  logic [7:0]                   flags;
  logic [atc_pkg::SRC_W-1:0]    sel;
  logic                         auto_en;
  logic                         trig;
  modport ctl (output flags, output sel, output auto_en, input trig);
  modport det (input flags, input sel, input auto_en, output trig);
endinterface

// ---- rtl/atc_edge_trig.sv ----
// Purpose: Rising-edge detector on the selected trigger flag
// Assumes: Flags are same-clock logic, no synchronising needed
// Notes:   Trigger output is combinational for a same-cycle start
`timescale 1ns/1ps
module atc_edge_trig (
  input wire logic clk,
  input wire logic reset_n,
  atc_trig_if.det  tif
);

  logic sel_flag;
  logic prev_r;

  // Pick one flag by source code
  function automatic logic src_flag(input logic [7:0] f,
                                    input logic [atc_pkg::SRC_W-1:0] s);
    src_flag = f[s];
  endfunction

  assign sel_flag = tif.auto_en & src_flag(tif.flags, tif.sel);

  // Last level of the selected signal; a new source is compared to it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_r <= 1'b0;
    else
      prev_r <= sel_flag;
  end

  assign tif.trig = sel_flag & ~prev_r;

  sel_switch_a: assert property (@(posedge clk) disable iff (!reset_n)
    tif.auto_en && $past(tif.auto_en) && $changed(tif.sel) &&
    src_flag(tif.flags, tif.sel) && !$past(sel_flag) |-> tif.trig)
    else $error("switch to set source gave no trigger");

endmodule

// ---- rtl/atc_conv_seq.sv ----
// Purpose: Conversion timing sequencer
// Assumes: One converter clock per system clock
// Notes:   First conversion after enable is the long one
`timescale 1ns/1ps
module atc_conv_seq (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  atc_pkg::atc_state_e state_r;
  logic [4:0]          cnt_r;
  logic                first_r;

  // disable aborts; start only when enabled and idle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= atc_pkg::ST_IDLE;
      cnt_r   <= 5'h00;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state_r)
        atc_pkg::ST_IDLE:
          if (enable && start)
          begin
            state_r <= atc_pkg::ST_CONV;
            cnt_r   <= first_r ? atc_pkg::FIRST_CONV_CLOCKS : atc_pkg::CONV_CLOCKS;
          end
        atc_pkg::ST_CONV:
          if (!enable)
            state_r <= atc_pkg::ST_IDLE;
          else if (cnt_r == 5'h01)
          begin
            state_r <= atc_pkg::ST_IDLE;
            done    <= 1'b1;
          end
          else
            cnt_r <= cnt_r - 5'h01;
      endcase
    end
  end

  // Long first conversion pending while off or until started
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      first_r <= 1'b1;
    else if (!enable)
      first_r <= 1'b1;
    else if (start && state_r == atc_pkg::ST_IDLE)
      first_r <= 1'b0;
  end

  assign busy = (state_r == atc_pkg::ST_CONV);

  // Completion comes only out of a running conversion
  done_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
    done |-> $past(busy) && $past(enable))
    else $error("done without a running conversion");

endmodule

// ---- rtl/atc_top.sv ----
// Purpose: Converter trigger select, comparator input steering and
//          digital input disable, with a small register port
// Assumes: Trigger flags come from same-clock logic; pins are async
// Notes:   Read data is registered and valid one cycle after the strobe
//
// How it works
// - Mux select and converter off: mux feeds comparator
// - Mux select zero: comparator pin feeds comparator
// - Trigger source ignored without auto-trigger
// - Selected flag rising edge starts conversion
// - Switching to a set flag triggers
// - Choosing free running never triggers itself
// - Sources 000 to 100 decode as listed
// - Sources 101 to 111 decode as listed
// - Disable bit turns off pin input buffer
// - Disabled pin reads as zero
// - Auto-trigger converts on each selected edge that arrives while enabled and idle
// - Enable powers converter; clearing aborts conversion
// - Done flag set when conversion completes
`timescale 1ns/1ps
module atc_top (
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Event flags from the timers, comparator and external interrupt
  input  wire logic       comp_out_flag,
  input  wire logic       ext_irq0_flag,
  input  wire logic       t0_cmpa_flag,
  input  wire logic       t0_ovf_flag,
  input  wire logic       t1_cmpb_flag,
  input  wire logic       t1_ovf_flag,
  input  wire logic       t1_cap_flag,
  // Analog pins seen as digital inputs
  input  wire logic [7:0] pins_in,
  output logic      [7:0] port_in_value,
  output logic      [7:0] buffer_off,
  // Converter and comparator steering
  output logic            comp_neg_from_mux,
  output logic            converter_on,
  output logic            conv_busy,
  output logic            conv_done
);

  // Register state
  logic                           en_r;
  logic                           auto_r;
  logic                           done_flag_r;
  logic                           mux_sel_r;
  logic [atc_pkg::SRC_W-1:0]      src_r;
  logic [7:0]                     dis_r;
  logic [7:0]                     rdata_r;
  logic                           comp_mux_r;
  logic [7:0]                     port_in_r;
  // Pin synchroniser stages
  logic [7:0]                     pin_s1_r;
  logic [7:0]                     pin_s2_r;
  // Decoded strobes
  logic                           wr_a;
  logic                           wr_b;
  logic                           wr_dis;
  logic                           soft_start;
  logic                           conv_start;
  logic                           trig;

  atc_trig_if tif ();

  // Address decode shared by every write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign wr_a   = reg_wr & hit(reg_addr, atc_pkg::CTRL_A_ADDR);
  assign wr_b   = reg_wr & hit(reg_addr, atc_pkg::CTRL_B_ADDR);
  assign wr_dis = reg_wr & hit(reg_addr, atc_pkg::DIS_ADDR);

  // Writing one to the start bit requests a conversion; zero does nothing
  assign soft_start = wr_a & reg_wdata[atc_pkg::A_START_BIT];

  assign conv_start = soft_start | trig;

  // converter_control_a: enable and auto-trigger bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_r   <= atc_pkg::CTRL_A_RST[atc_pkg::A_EN_BIT];
      auto_r <= atc_pkg::CTRL_A_RST[atc_pkg::A_AUTO_BIT];
    end
    else if (wr_a)
    begin
      en_r   <= reg_wdata[atc_pkg::A_EN_BIT];
      auto_r <= reg_wdata[atc_pkg::A_AUTO_BIT];
    end
  end

  // done flag, set wins over write-one clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      done_flag_r <= atc_pkg::CTRL_A_RST[atc_pkg::A_DONE_BIT];
    else if (conv_done)
      done_flag_r <= 1'b1;
    else if (wr_a && reg_wdata[atc_pkg::A_DONE_BIT])
      done_flag_r <= 1'b0;
  end

  // converter_control_b: comparator mux select and trigger source
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mux_sel_r <= atc_pkg::CTRL_B_RST[atc_pkg::B_MUX_BIT];
      src_r     <= atc_pkg::CTRL_B_RST[atc_pkg::B_SRC_LSB +: atc_pkg::SRC_W];
    end
    else if (wr_b)
    begin
      mux_sel_r <= reg_wdata[atc_pkg::B_MUX_BIT];
      src_r     <= reg_wdata[atc_pkg::B_SRC_LSB +: atc_pkg::SRC_W];
    end
  end

  // analog_pin_digital_disable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dis_r <= atc_pkg::DIS_RST;
    else if (wr_dis)
      dis_r <= reg_wdata;
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        atc_pkg::CTRL_A_ADDR:
          rdata_r <= {en_r, conv_busy, auto_r, done_flag_r, 4'h0};
        atc_pkg::CTRL_B_ADDR:
          rdata_r <= {1'b0, mux_sel_r, 3'h0, src_r};
        atc_pkg::DIS_ADDR:
          rdata_r <= dis_r;
        default:
          rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata = rdata_r;

  // timer1 sources at 101 to 111
  // free running rides on the done pulse
  // done pulse, not the flag, so selection alone never fires
  assign tif.flags[atc_pkg::SRC_FREE]    = conv_done;
  assign tif.flags[atc_pkg::SRC_COMP]    = comp_out_flag;
  assign tif.flags[atc_pkg::SRC_EXT0]    = ext_irq0_flag;
  assign tif.flags[atc_pkg::SRC_T0_CMPA] = t0_cmpa_flag;
  assign tif.flags[atc_pkg::SRC_T0_OVF]  = t0_ovf_flag;
  assign tif.flags[atc_pkg::SRC_T1_CMPB] = t1_cmpb_flag;
  assign tif.flags[atc_pkg::SRC_T1_OVF]  = t1_ovf_flag;
  assign tif.flags[atc_pkg::SRC_T1_CAP]  = t1_cap_flag;
  assign tif.sel                         = src_r;
  // field has no effect when auto-trigger is off
  assign tif.auto_en                     = auto_r;
  assign trig                            = tif.trig;

  atc_edge_trig u_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  atc_conv_seq u_seq (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (en_r),
    .start   (conv_start),
    .busy    (conv_busy),
    .done    (conv_done)
  );

  // Converter power follows the enable bit
  assign converter_on = en_r;

  // mux to comparator only while converter is off
  // otherwise the dedicated pin is used
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      comp_mux_r <= 1'b0;
    else
      comp_mux_r <= mux_sel_r & ~en_r;
  end

  assign comp_neg_from_mux = comp_mux_r;

  // Pins are asynchronous; the first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end
    else
    begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      port_in_r <= 8'h00;
    else
      port_in_r <= pin_s2_r & ~dis_r;
  end

  assign port_in_value = port_in_r;

  // buffer enables follow the disable bits; saves input power
  assign buffer_off = dis_r;

  // Checks below run on the system clock, off while in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Software start as a write with the start bit and converter on
  sequence soft_start_s;
    soft_start && en_r && !conv_busy;
  endsequence

  // A started conversion stays busy for at least two cycles
  sequence held_busy_s;
    conv_busy ##1 conv_busy;
  endsequence

  property start_runs_p;
    soft_start_s |=> held_busy_s;
  endproperty

  // Completion followed by the flag and a fresh run in free mode
  sequence free_done_s;
    conv_done && auto_r && en_r && src_r == atc_pkg::SRC_FREE;
  endsequence

  soft_start_a: assert property (start_runs_p)
    else $error("software start did not run a conversion");

  comp_mux_route_a: assert property (
    mux_sel_r && !en_r |=> comp_neg_from_mux)
    else $error("comparator not fed from converter mux");

  comp_pin_route_a: assert property (
    !mux_sel_r || en_r |=> !comp_neg_from_mux)
    else $error("comparator not fed from its pin");

  auto_off_ignore_a: assert property (
    !auto_r |-> !trig)
    else $error("trigger while auto-trigger is off");

  edge_start_a: assert property (
    trig && en_r && !conv_busy |=> conv_busy)
    else $error("selected edge did not start a conversion");

  free_no_trig_a: assert property (
    $changed(src_r) && src_r == atc_pkg::SRC_FREE && !conv_done |-> !trig)
    else $error("selecting free running caused a trigger");

  src_decode_a: assert property (
    auto_r && $past(auto_r) && $stable(src_r) && src_r == atc_pkg::SRC_COMP
    && comp_out_flag && !$past(comp_out_flag) |-> trig)
    else $error("comparator source not decoded");

  t1_decode_a: assert property (
    auto_r && $past(auto_r) && $stable(src_r) && src_r == atc_pkg::SRC_T1_CAP
    && t1_cap_flag && !$past(t1_cap_flag) |-> trig)
    else $error("timer one capture source not decoded");

  buffer_off_a: assert property (
    wr_dis |=> buffer_off == $past(reg_wdata))
    else $error("buffer disable not taken from write");

  input_zero_a: assert property (
    1'b1 |=> (port_in_value & $past(dis_r)) == 8'h00)
    else $error("disabled pin read as one");

  auto_each_a: assert property (
    auto_r && trig && en_r && !conv_busy |=> conv_busy ##1 conv_busy)
    else $error("auto-trigger edge lost");

  enable_abort_a: assert property (
    !en_r |=> !conv_busy)
    else $error("conversion runs with converter off");

  done_flag_a: assert property (
    conv_done |=> done_flag_r)
    else $error("done flag not set on completion");

  free_restart_a: assert property (
    free_done_s |=> conv_busy && done_flag_r)
    else $error("free running did not restart");

  // Set and write-one clear in one cycle: the completion must survive
  done_wins_a: assert property (
    conv_done && wr_a && reg_wdata[atc_pkg::A_DONE_BIT] |=> done_flag_r)
    else $error("done flag lost to a same-cycle clear");

  // Read data stands only in the cycle after a read strobe
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without a read strobe");

  // Converter power follows the written enable bit
  power_follow_a: assert property (
    wr_a |=> converter_on == $past(reg_wdata[atc_pkg::A_EN_BIT]))
    else $error("converter power not taken from write");

  // In free running only a completion may fire, never the selection
  free_level_a: assert property (
    src_r == atc_pkg::SRC_FREE && trig |-> conv_done)
    else $error("free running fired without a completion");

  // Busy cycles of the running conversion, for the length check
  logic [4:0]                     busy_cnt_r;

  // Cleared whenever idle, so back-to-back runs count from zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_cnt_r <= 5'h00;
    else if (conv_busy)
      busy_cnt_r <= busy_cnt_r + 5'h01;
    else
      busy_cnt_r <= 5'h00;
  end

  // A completed run lasted one of the two documented lengths
  conv_length_a: assert property (
    conv_done |-> busy_cnt_r == atc_pkg::CONV_CLOCKS
    || busy_cnt_r == atc_pkg::FIRST_CONV_CLOCKS)
    else $error("conversion finished after a wrong length");

endmodule

// ---- verif/atc_flag_model.sv ----
// Purpose: Event flag sources seen by the trigger control
// Assumes: Timers, comparator and interrupt logic share the system clock
// Notes:   Flags are levels that follow the request one edge later
`timescale 1ns/1ps
module atc_flag_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [6:0] flag_req,
  output logic      [6:0] flags
);
  // Flags move on a clock edge, as a real timer flag would, never mid-cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags <= 7'h00;
    else
      flags <= flag_req;
  end
endmodule

// ---- verif/tb_adc_trigger_select_and_input_disable.sv ----
// Purpose: Self-checking bench for the converter trigger control
// Assumes: One 100 MHz clock, registers on the plain byte port
// Notes:   Flag order in the model is source code minus one
`timescale 1ns/1ps
module tb_adc_trigger_select_and_input_disable;
  logic       clk        = 1'b0;
  logic       reset_n    = 1'b0;
  logic [7:0] reg_addr   = 8'h00;
  logic [7:0] reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic [7:0] pins_in    = 8'h00;
  logic [6:0] flag_req   = 7'h00;
  logic [6:0] flags;
  logic [7:0] reg_rdata;
  logic [7:0] port_in_value;
  logic [7:0] buffer_off;
  logic       comp_neg_from_mux;
  logic       converter_on;
  logic       conv_busy;
  logic       conv_done;
  int         num_errors   = 0;
  int         total_checks = 0;

  // Free-running system clock
  always #5 clk = ~clk;

  atc_flag_model flag_u (
    .clk      (clk),
    .reset_n  (reset_n),
    .flag_req (flag_req),
    .flags    (flags)
  );

  atc_top dut_u (
    .clk               (clk),
    .reset_n           (reset_n),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .comp_out_flag     (flags[0]),
    .ext_irq0_flag     (flags[1]),
    .t0_cmpa_flag      (flags[2]),
    .t0_ovf_flag       (flags[3]),
    .t1_cmpb_flag      (flags[4]),
    .t1_ovf_flag       (flags[5]),
    .t1_cap_flag       (flags[6]),
    .pins_in           (pins_in),
    .port_in_value     (port_in_value),
    .buffer_off        (buffer_off),
    .comp_neg_from_mux (comp_neg_from_mux),
    .converter_on      (converter_on),
    .conv_busy         (conv_busy),
    .conv_done         (conv_done)
  );

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus cycles; each waits an edge first so strobes never toggle twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for busy, then time from busy to the done pulse
  task automatic wait_conv(input logic [4:0] len);
    int i;
    int n;
    i = 0;
    n = 0;
    #1;
    while (conv_busy !== 1'b1 && i < 6)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (conv_busy === 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), {3'h0, len});
    chk({7'h00, conv_done}, 8'h01);
  endtask

  // No conversion may start over the next n cycles
  task automatic no_conv(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      seen = seen | conv_busy;
    end
    chk({7'h00, seen}, 8'h00);
  endtask

  task automatic t_reset;
    rd(atc_pkg::CTRL_A_ADDR, atc_pkg::CTRL_A_RST);
    rd(atc_pkg::CTRL_B_ADDR, atc_pkg::CTRL_B_RST);
    rd(atc_pkg::DIS_ADDR, atc_pkg::DIS_RST);
    rd(8'h55, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(atc_pkg::CTRL_B_ADDR, 8'h47);
    rd(atc_pkg::CTRL_B_ADDR, 8'h47);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    // Software turns off buffers of analog pins it does not read
    wr(atc_pkg::DIS_ADDR, 8'ha5);
    rd(atc_pkg::DIS_ADDR, 8'ha5);
    chk(buffer_off, 8'ha5);
    @(posedge clk);
    pins_in <= 8'hff;
    cyc(5);
    chk(port_in_value, 8'h5a);
    wr(atc_pkg::DIS_ADDR, 8'h00);
    wr(atc_pkg::CTRL_B_ADDR, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_steer;
    wr(atc_pkg::CTRL_B_ADDR, 8'h40);
    cyc(2);
    chk({7'h00, comp_neg_from_mux}, 8'h01);
    wr(atc_pkg::CTRL_A_ADDR, 8'h80);
    cyc(2);
    chk({7'h00, comp_neg_from_mux}, 8'h00);
    chk({7'h00, converter_on}, 8'h01);
    wr(atc_pkg::CTRL_A_ADDR, 8'h00);
    wr(atc_pkg::CTRL_B_ADDR, 8'h00);
    cyc(2);
    chk({7'h00, comp_neg_from_mux}, 8'h00);
    $display("test steering done");
  endtask

  task automatic t_single;
    // The sequencer takes a start only once the enable bit already stands
    wr(atc_pkg::CTRL_A_ADDR, 8'h80);
    wr(atc_pkg::CTRL_A_ADDR, 8'hc0);
    wait_conv(atc_pkg::FIRST_CONV_CLOCKS);
    cyc(2);
    rd(atc_pkg::CTRL_A_ADDR, 8'h90);
    wr(atc_pkg::CTRL_A_ADDR, 8'h90);
    rd(atc_pkg::CTRL_A_ADDR, 8'h80);
    $display("test single done");
  endtask

  task automatic t_sources;
    wr(atc_pkg::CTRL_A_ADDR, 8'ha0);
    for (int s = 1; s < 8; s++)
    begin
      wr(atc_pkg::CTRL_B_ADDR, 8'(s));
      @(posedge clk);
      flag_req <= 7'(1 << (s - 1));
      wait_conv(atc_pkg::CONV_CLOCKS);
      @(posedge clk);
      flag_req <= 7'h00;
      cyc(2);
    end
    $display("test sources done");
  endtask

  task automatic t_gating;
    wr(atc_pkg::CTRL_A_ADDR, 8'h80);
    wr(atc_pkg::CTRL_B_ADDR, 8'h03);
    @(posedge clk);
    flag_req <= 7'h04;
    no_conv(6);
    @(posedge clk);
    flag_req <= 7'h20;
    wr(atc_pkg::CTRL_A_ADDR, 8'ha0);
    no_conv(4);
    wr(atc_pkg::CTRL_B_ADDR, 8'h06);
    wait_conv(atc_pkg::CONV_CLOCKS);
    @(posedge clk);
    flag_req <= 7'h00;
    wr(atc_pkg::CTRL_B_ADDR, 8'h00);
    no_conv(6);
    $display("test gating done");
  endtask

  task automatic t_free;
    wr(atc_pkg::CTRL_A_ADDR, 8'he0);
    wait_conv(atc_pkg::CONV_CLOCKS);
    wait_conv(atc_pkg::CONV_CLOCKS);
    cyc(3);
    wr(atc_pkg::CTRL_A_ADDR, 8'h00);
    cyc(2);
    chk({6'h00, converter_on, conv_busy}, 8'h00);
    $display("test free running done");
  endtask

  // Single exit point for normal end and watchdog
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_steer();
    t_single();
    t_sources();
    t_gating();
    t_free();
    complete_run();
  end

  // Watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
